// file: ptm_pkg.sv
// ptm_pkg: constants and types shared by the flag and buffer block.
// assumes one 100 MHz clock and a synchronous active-high reset.
//
// Functional notes
// - each event source sets its own flag
// - irq level high while flag and enable
// - clear needs read-while-set then zero write
// - new event between steps restarts clearing
// - up mode overflow at modulo or FFFF wrap
// - center mode overflow at up-to-down turn
// - capture edge select: none, rise, fall, both
// - compare flag on counter equals value
// - edge pwm flag at duty end match
// - center pwm flag at both matches
// - counter write clears counter and prescaler
// - debug reads return frozen live counter
// - debug writes clear counter read latch
// - debug channel reads direct, latch cleared
// - capture mode ignores channel value writes
// - compare loads buffer at next increment
// - pwm loads buffer at modulo-minus-one step
// - center pwm value equals modulo: full duty
// - value modulo-minus-one: nearly full duty
// - zero to nonzero waits next period
// - nonzero to zero finishes current period
// - debug control write drops modulo bytes
// - no clock source: load on second byte
// - interrupt request is active high
package ptm_pkg;

    // ------------------------------------------------------------
    // widths and reset values
    // ------------------------------------------------------------
    localparam logic [15:0] PTM_ZERO16 = 16'h0000;
    localparam logic [15:0] PTM_ALL16 = 16'hFFFF;
    localparam logic [15:0] PTM_ONE16 = 16'h0001;
    localparam logic [15:0] PTM_PRESC_RST = 16'h0000;

    // channel modes decoded from control bits
    typedef enum logic [1:0]
    {
        PTM_MODE_CAPTURE = 2'b00,
        PTM_MODE_COMPARE = 2'b01,
        PTM_MODE_EDGE_PWM = 2'b10,
        PTM_MODE_CENTER_PWM = 2'b11
    } ptm_mode_e;

    // one software access to a byte-wide register pair
    typedef struct packed
    {
        logic rd_hi;
        logic rd_lo;
        logic wr_hi;
        logic wr_lo;
        logic [7:0] wdata;
    } ptm_byte_acc_s;

    // counter status shared by the channel cells
    typedef struct packed
    {
        logic step;
        logic up;
        logic [15:0] count;
    } ptm_cnt_s;

endpackage : ptm_pkg

// file: ptm_flag.sv
// ptm_flag: one event flag with the read-then-write-zero clearing handshake.
// assumes set, read and write strobes are single-cycle pulses on clk.
`timescale 1ns/10ps
`default_nettype none
module ptm_flag
    import ptm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic set_evt,
    input wire logic rd_stb,
    input wire logic wr_stb,
    input wire logic wr_bit,
    input wire logic irq_en,
    output logic flag,
    output logic irq
);

    // ------------------------------------------------------------
    // handshake state
    // ------------------------------------------------------------
    logic armed_reg; // a read saw the flag set

    // arm on a read of a set flag; a new event disarms so the write fails
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            armed_reg <= 1'b0;
        end
        else if (set_evt)
        begin
            armed_reg <= 1'b0;
        end
        else if (rd_stb && flag)
        begin
            armed_reg <= 1'b1;
        end
        else if (wr_stb)
        begin
            armed_reg <= 1'b0;
        end
    end

    // set beats clear so no event is lost
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            flag <= 1'b0;
        end
        else if (set_evt)
        begin
            flag <= 1'b1;
        end
        else if (wr_stb && !wr_bit && armed_reg)
        begin
            flag <= 1'b0;
        end
    end

    // registered level request
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            irq <= 1'b0;
        end
        else
        begin
            irq <= irq_en && (set_evt || (flag && !(wr_stb && !wr_bit && armed_reg)));
        end
    end

endmodule : ptm_flag
`default_nettype wire

// file: ptm_chan.sv
// ptm_chan: one channel's value buffer, event detection and pwm output.
// assumes a synchronised capture pin and counter status from the parent.
`timescale 1ns/10ps
`default_nettype none
module ptm_chan
    import ptm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire ptm_mode_e mode,
    input wire logic [1:0] edge_sel,
    input wire logic clk_running,
    input wire ptm_cnt_s cnt,
    input wire logic [15:0] modulo,
    input wire logic pre_top,
    input wire logic period_start,
    input wire logic pin_sync,
    input wire ptm_byte_acc_s acc,
    input wire logic csc_wr,
    output logic event_pulse,
    output logic pwm_out,
    output logic [15:0] value
);

    // ------------------------------------------------------------
    // buffer state
    // ------------------------------------------------------------
    logic [7:0] buf_hi_reg; // pending high byte
    logic [7:0] buf_lo_reg; // pending low byte
    logic got_hi_reg; // high byte written
    logic got_lo_reg; // low byte written
    logic pin_prev_reg; // previous pin level
    logic [15:0] active_reg; // value used by center pwm this period
    logic load;

    // pick the moment the buffer moves into the live value
    always_comb
    begin
        load = 1'b0;
        if (got_hi_reg && got_lo_reg)
        begin
            if (!clk_running)
                load = 1'b1;
            else if (mode == PTM_MODE_COMPARE)
                load = cnt.step;
            else
                load = pre_top;
        end
    end

    // capture the written bytes; control writes drop them
    always_ff @(posedge clk)
    begin
        if (srst || csc_wr || load)
        begin
            got_hi_reg <= 1'b0;
            got_lo_reg <= 1'b0;
        end
        else if (mode != PTM_MODE_CAPTURE)
        begin
            if (acc.wr_hi)
            begin
                buf_hi_reg <= acc.wdata;
                got_hi_reg <= 1'b1;
            end
            if (acc.wr_lo)
            begin
                buf_lo_reg <= acc.wdata;
                got_lo_reg <= 1'b1;
            end
        end
    end

    // live channel value; capture mode stores the counter on an edge
    always_ff @(posedge clk)
    begin
        if (srst)
            value <= PTM_ZERO16;
        else if (mode == PTM_MODE_CAPTURE && event_pulse)
            value <= cnt.count;
        else if (load)
            value <= {buf_hi_reg, buf_lo_reg};
    end

    // center pwm latches duty at period start only
    always_ff @(posedge clk)
    begin
        if (srst)
            active_reg <= PTM_ZERO16;
        else if (period_start || mode != PTM_MODE_CENTER_PWM)
            active_reg <= value;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            pin_prev_reg <= 1'b0;
        else
            pin_prev_reg <= pin_sync;
    end

    // one pulse per recognised event
    always_ff @(posedge clk)
    begin
        if (srst)
            event_pulse <= 1'b0;
        else
        begin
            unique case (mode)
                PTM_MODE_CAPTURE:
                    event_pulse <= (edge_sel[0] && pin_sync && !pin_prev_reg) ||
                        (edge_sel[1] && !pin_sync && pin_prev_reg);
                PTM_MODE_COMPARE, PTM_MODE_EDGE_PWM:
                    event_pulse <= cnt.step && (cnt.count == value);
                PTM_MODE_CENTER_PWM:
                    event_pulse <= cnt.step && (cnt.count == active_reg);
            endcase
        end
    end

    // pwm drive, high-true duty
    always_ff @(posedge clk)
    begin
        if (srst)
            pwm_out <= 1'b0;
        else if (mode == PTM_MODE_EDGE_PWM)
            pwm_out <= (value > modulo) || (cnt.count < value);
        else if (mode == PTM_MODE_CENTER_PWM)
            pwm_out <= !active_reg[15] && (active_reg != PTM_ZERO16) &&
                ((active_reg >= modulo) || (cnt.count < active_reg) ||
                (cnt.count == active_reg && !cnt.up));
        else
            pwm_out <= 1'b0;
    end

endmodule : ptm_chan
`default_nettype wire

// file: ptm_top.sv
// ptm_top: counter status, overflow and channel flags, buffers and debug coherency.
// assumes byte access strobes come from the bus on clk; capture pins are asynchronous.
`timescale 1ns/10ps
`default_nettype none
module ptm_top
    import ptm_pkg::*;
(
    input wire logic clk,
    input wire logic srst,
    input wire logic debug_halt_mode,
    input wire logic center_aligned_select,
    input wire logic clock_source_sel_hi,
    input wire logic clock_source_sel_lo,
    input wire logic [15:0] prescale_div,
    input wire logic overflow_irq_enable,
    input wire logic timer_status_control_wr,
    input wire logic timer_status_control_rd,
    input wire logic timer_status_control_wbit,
    input wire ptm_byte_acc_s counter_acc,
    input wire ptm_byte_acc_s modulo_acc,
    input wire ptm_byte_acc_s [1:0] chan_value_acc,
    input wire logic [1:0] channel_status_control_wr,
    input wire logic [1:0] channel_status_control_rd,
    input wire logic [1:0] channel_status_control_wbit,
    input wire ptm_mode_e [1:0] chan_mode,
    input wire logic [1:0] edge_level_sel_hi,
    input wire logic [1:0] edge_level_sel_lo,
    input wire logic [1:0] channel_irq_enable,
    input wire logic [1:0] capture_pin,
    output logic overflow_flag,
    output logic overflow_irq,
    output logic [1:0] channel_event_flag,
    output logic [1:0] channel_irq,
    output logic [15:0] counter_read,
    output logic [1:0][15:0] chan_value_read,
    output logic [1:0] pwm_pin,
    output logic [15:0] modulo_value
);

    // ------------------------------------------------------------
    // counter core
    // ------------------------------------------------------------
    logic [15:0] count_reg; // main counter
    logic [15:0] presc_reg; // prescaler counter
    logic up_reg; // counting direction
    logic [7:0] cnt_latch_reg; // low byte held after a high read
    logic cnt_latch_vld_reg; // read coherency latch valid
    logic [7:0] mod_buf_reg; // pending modulo high byte
    logic mod_got_hi_reg; // modulo high byte written
    logic [1:0] sync1_reg; // first synchroniser stage
    logic [1:0] sync2_reg; // second synchroniser stage
    logic ovf_evt;
    logic step;
    logic running;
    logic [15:0] top;
    logic pre_top;
    logic [1:0] chan_evt;
    logic [1:0][15:0] chan_val;
    ptm_cnt_s cnt_info;

    assign running = clock_source_sel_hi || clock_source_sel_lo;
    // zero modulo means free running to all ones
    assign top = (modulo_value == PTM_ZERO16) ? PTM_ALL16 : modulo_value;
    // counter frozen while halted for debug
    assign step = running && !debug_halt_mode && (presc_reg == prescale_div);
    assign pre_top = step && up_reg && (count_reg == top - PTM_ONE16);
    assign cnt_info = '{step: step, up: up_reg, count: count_reg};

    assign ovf_evt = step && (count_reg == top) && (center_aligned_select || up_reg);

    // prescaler, cleared with the counter
    always_ff @(posedge clk)
    begin
        if (srst || counter_acc.wr_hi || counter_acc.wr_lo || step)
            presc_reg <= PTM_PRESC_RST;
        else if (running && !debug_halt_mode)
            presc_reg <= presc_reg + PTM_ONE16;
    end

    // main counter, up or up/down
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            count_reg <= PTM_ZERO16;
            up_reg <= 1'b1;
        end
        else if (counter_acc.wr_hi || counter_acc.wr_lo)
        begin
            count_reg <= PTM_ZERO16;
            up_reg <= 1'b1;
        end
        else if (step)
        begin
            if (!center_aligned_select)
            begin
                up_reg <= 1'b1;
                count_reg <= (count_reg == top) ? PTM_ZERO16 : count_reg + PTM_ONE16;
            end
            else if (up_reg && count_reg >= top)
            begin
                up_reg <= 1'b0;
                count_reg <= count_reg - PTM_ONE16;
            end
            else if (!up_reg && count_reg == PTM_ZERO16)
            begin
                up_reg <= 1'b1;
                count_reg <= PTM_ONE16;
            end
            else
                count_reg <= up_reg ? count_reg + PTM_ONE16 : count_reg - PTM_ONE16;
        end
    end

    // ------------------------------------------------------------
    // counter read coherency
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            cnt_latch_reg <= 8'h00;
            cnt_latch_vld_reg <= 1'b0;
        end
        else if (debug_halt_mode && (timer_status_control_wr ||
            counter_acc.wr_hi || counter_acc.wr_lo))
            cnt_latch_vld_reg <= 1'b0;
        else if (!debug_halt_mode && counter_acc.rd_hi)
        begin
            cnt_latch_reg <= count_reg[7:0];
            cnt_latch_vld_reg <= 1'b1;
        end
        else if (counter_acc.rd_lo)
            cnt_latch_vld_reg <= 1'b0;
    end

    always_ff @(posedge clk)
    begin
        if (srst)
            counter_read <= PTM_ZERO16;
        else if (!debug_halt_mode && cnt_latch_vld_reg)
            counter_read <= {count_reg[15:8], cnt_latch_reg};
        else
            counter_read <= count_reg;
    end

    // ------------------------------------------------------------
    // modulo buffer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            mod_buf_reg <= 8'h00;
            mod_got_hi_reg <= 1'b0;
            modulo_value <= PTM_ZERO16;
        end
        else if (timer_status_control_wr)
            mod_got_hi_reg <= 1'b0;
        else if (modulo_acc.wr_hi)
        begin
            mod_buf_reg <= modulo_acc.wdata;
            mod_got_hi_reg <= 1'b1;
        end
        else if (modulo_acc.wr_lo && mod_got_hi_reg)
        begin
            modulo_value <= {mod_buf_reg, modulo_acc.wdata};
            mod_got_hi_reg <= 1'b0;
        end
    end

    // capture pins pass two flip-flops before use
    always_ff @(posedge clk)
    begin
        if (srst)
        begin
            sync1_reg <= 2'b00;
            sync2_reg <= 2'b00;
        end
        else
        begin
            sync1_reg <= capture_pin;
            sync2_reg <= sync1_reg;
        end
    end

    // ------------------------------------------------------------
    // overflow flag and channels
    // ------------------------------------------------------------
    ptm_flag u_ovf_flag (
        .clk(clk),
        .srst(srst),
        .set_evt(ovf_evt),
        .rd_stb(timer_status_control_rd),
        .wr_stb(timer_status_control_wr),
        .wr_bit(timer_status_control_wbit),
        .irq_en(overflow_irq_enable),
        .flag(overflow_flag),
        .irq(overflow_irq)
    );

    for (genvar i = 0; i < 2; i++)
    begin : g_chan
        ptm_chan u_chan (
            .clk(clk),
            .srst(srst),
            .mode(chan_mode[i]),
            .edge_sel({edge_level_sel_hi[i], edge_level_sel_lo[i]}),
            .clk_running(running),
            .cnt(cnt_info),
            .modulo(top),
            .pre_top(pre_top),
            .period_start(ovf_evt),
            .pin_sync(sync2_reg[i]),
            .acc(chan_value_acc[i]),
            .csc_wr(channel_status_control_wr[i]),
            .event_pulse(chan_evt[i]),
            .pwm_out(pwm_pin[i]),
            .value(chan_val[i])
        );

        ptm_flag u_chan_flag (
            .clk(clk),
            .srst(srst),
            .set_evt(chan_evt[i]),
            .rd_stb(channel_status_control_rd[i]),
            .wr_stb(channel_status_control_wr[i]),
            .wr_bit(channel_status_control_wbit[i]),
            .irq_en(channel_irq_enable[i]),
            .flag(channel_event_flag[i]),
            .irq(channel_irq[i])
        );

        always_ff @(posedge clk)
        begin
            if (srst)
                chan_value_read[i] <= PTM_ZERO16;
            else
                chan_value_read[i] <= chan_val[i];
        end
    end

endmodule : ptm_top
`default_nettype wire

// file: ptm_properties.sv
// ptm_properties: checks on flag and request ports of ptm_top.
// assumes one clock domain and the synchronous active-high reset srst.
`timescale 1ns/10ps
`default_nettype none
module ptm_properties
(
    input wire logic clk,
    input wire logic srst,
    input wire logic overflow_irq_enable,
    input wire logic timer_status_control_wr,
    input wire logic timer_status_control_wbit,
    input wire logic [1:0] channel_status_control_wr,
    input wire logic [1:0] channel_status_control_wbit,
    input wire logic [1:0] channel_irq_enable,
    input wire logic overflow_flag,
    input wire logic overflow_irq,
    input wire logic [1:0] channel_event_flag,
    input wire logic [1:0] channel_irq
);
    // ------------------------------------------------------------
    // flag and request relations
    // ------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (srst);

    // request follows a flag that has stood with its enable for a cycle
    a_ovf_irq_on: assert property (
        overflow_flag && overflow_irq_enable && $past(overflow_flag && overflow_irq_enable)
        |-> overflow_irq) else $error("overflow request missing");
    a_ovf_irq_cause: assert property (overflow_irq |-> overflow_flag)
        else $error("overflow request without flag");
    a_ovf_irq_off: assert property (
        !overflow_irq_enable && !$past(overflow_irq_enable) |-> !overflow_irq)
        else $error("overflow request while disabled");
    a_chan_irq_on: assert property (
        ((channel_event_flag & channel_irq_enable
        & $past(channel_event_flag & channel_irq_enable)) & ~channel_irq) == 2'h0)
        else $error("channel request missing");
    a_chan_irq_cause: assert property ((channel_irq & ~channel_event_flag) == 2'h0)
        else $error("channel request without flag");
    // a set flag only drops on a zero write
    a_ovf_flag_hold: assert property (
        overflow_flag && !timer_status_control_wr |=> overflow_flag)
        else $error("overflow flag dropped without write");
    a_ovf_one_ignored: assert property (
        overflow_flag && timer_status_control_wr && timer_status_control_wbit
        |=> overflow_flag) else $error("one write cleared overflow flag");
    a_ovf_clear_qual: assert property (
        $fell(overflow_flag) && !$past(srst)
        |-> $past(timer_status_control_wr && !timer_status_control_wbit))
        else $error("overflow flag cleared without zero write");
    a_chan_clear_qual: assert property (
        !$past(srst) |-> ($past(channel_event_flag) & ~channel_event_flag
        & ~$past(channel_status_control_wr & ~channel_status_control_wbit)) == 2'h0)
        else $error("channel flag cleared without zero write");

    c_ovf_clear: cover property ($fell(overflow_flag));
    c_ovf_irq: cover property (overflow_irq);
    c_chan_irq: cover property (|channel_irq);
endmodule : ptm_properties

bind ptm_top ptm_properties u_props (.clk(clk), .srst(srst),
    .overflow_irq_enable(overflow_irq_enable),
    .timer_status_control_wr(timer_status_control_wr),
    .timer_status_control_wbit(timer_status_control_wbit),
    .channel_status_control_wr(channel_status_control_wr),
    .channel_status_control_wbit(channel_status_control_wbit),
    .channel_irq_enable(channel_irq_enable), .overflow_flag(overflow_flag),
    .overflow_irq(overflow_irq), .channel_event_flag(channel_event_flag),
    .channel_irq(channel_irq));
`default_nettype wire

// file: ptm_pin_model.sv
// ptm_pin_model: far side of the channel pins; drives capture inputs, watches pwm output 0.
// assumes level requests from the bench change at the falling edge of clk.
`timescale 1ns/10ps
`default_nettype none
module ptm_pin_model
(
    input wire logic clk,
    input wire logic srst,
    input wire logic [1:0] level_req,
    input wire logic [1:0] pwm_pin,
    output logic [1:0] capture_pin,
    output logic [15:0] pwm_edges
);
    logic pwm_last_reg; // previous pwm level
    // source moves just after a rising edge
    always_ff @(posedge clk)
    begin
        capture_pin <= level_req;
    end
    // count toggles so a steady output can be judged
    always_ff @(posedge clk)
    begin
        pwm_last_reg <= pwm_pin[0];
        if (srst)
            pwm_edges <= 16'h0000;
        else if (pwm_pin[0] != pwm_last_reg)
            pwm_edges <= pwm_edges + 16'h0001;
    end
endmodule : ptm_pin_model
`default_nettype wire

// file: ptm_top_tb.sv
// ptm_top_tb: directed scenarios for flags, buffers and debug reads of ptm_top.
// assumes ptm_properties is bound and ptm_pin_model drives the capture pins.
`timescale 1ns/10ps
`default_nettype none
module ptm_top_tb
    import ptm_pkg::*;
;
    logic clk, srst, dbg, cas, cs_hi, cs_lo, oie, tsc_wr, tsc_rd, tsc_wbit, ovf_f, ovf_i;
    logic [15:0] pdiv, cnt_rd, modv, edges, v, e;
    ptm_byte_acc_s cnt_acc, mod_acc;
    ptm_byte_acc_s [1:0] cv_acc;
    ptm_mode_e [1:0] mode;
    logic [1:0] csc_wr, csc_rd, csc_wbit, els_hi, els_lo, cie, lvl, cap, ch_f, ch_i, pwm;
    logic [1:0][15:0] cv_rd;
    int err_total, num_checks;
    time t1, t2, t3;

    ptm_top dut (.clk(clk), .srst(srst), .debug_halt_mode(dbg), .center_aligned_select(cas),
        .clock_source_sel_hi(cs_hi), .clock_source_sel_lo(cs_lo), .prescale_div(pdiv),
        .overflow_irq_enable(oie), .timer_status_control_wr(tsc_wr),
        .timer_status_control_rd(tsc_rd), .timer_status_control_wbit(tsc_wbit),
        .counter_acc(cnt_acc), .modulo_acc(mod_acc), .chan_value_acc(cv_acc),
        .channel_status_control_wr(csc_wr), .channel_status_control_rd(csc_rd),
        .channel_status_control_wbit(csc_wbit), .chan_mode(mode),
        .edge_level_sel_hi(els_hi), .edge_level_sel_lo(els_lo), .channel_irq_enable(cie),
        .capture_pin(cap), .overflow_flag(ovf_f), .overflow_irq(ovf_i),
        .channel_event_flag(ch_f), .channel_irq(ch_i), .counter_read(cnt_rd),
        .chan_value_read(cv_rd), .pwm_pin(pwm), .modulo_value(modv));
    ptm_pin_model u_pins (.clk(clk), .srst(srst), .level_req(lvl), .pwm_pin(pwm),
        .capture_pin(cap), .pwm_edges(edges));

    initial
    begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp, input string what);
        num_checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("FAIL t=%0t %s: seen %h expected %h", $time, what, seen, exp);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    // tgt 0 counter, 1 modulo, 2/3 channel value; op {rd_hi,rd_lo,wr_hi,wr_lo}
    task automatic bus(input int tgt, input logic [3:0] op, input logic [7:0] d);
        if (tgt == 0) cnt_acc = {op, d};
        else if (tgt == 1) mod_acc = {op, d};
        else cv_acc[tgt-2] = {op, d};
        cyc(1);
        {cnt_acc, mod_acc, cv_acc} = '0;
        cyc(1);
    endtask : bus
    // src 2 overflow flag, 0/1 channel flags
    task automatic flag_op(input int src, input logic rd, input logic wr, input logic wb);
        if (src == 2) {tsc_rd, tsc_wr, tsc_wbit} = {rd, wr, wb};
        else {csc_rd[src], csc_wr[src], csc_wbit[src]} = {rd, wr, wb};
        cyc(1);
        {tsc_rd, tsc_wr, tsc_wbit, csc_rd, csc_wr, csc_wbit} = 9'h000;
        cyc(1);
    endtask : flag_op
    task automatic clr(input int src);
        flag_op(src, 1'b1, 1'b0, 1'b0);
        flag_op(src, 1'b0, 1'b1, 1'b0);
    endtask : clr
    task automatic wait_flag(input int src, output time t);
        for (int i = 0; i < 3000; i++)
        begin
            cyc(1);
            t = $time;
            if ((src == 2 ? ovf_f : ch_f[src]) === 1'b1) return;
        end
        chk(16'h0000, 16'h0001, "flag timeout");
        tally_and_finish();
    endtask : wait_flag

    task automatic t_overflow();
        bus(1, 4'h2, 8'h00);
        bus(1, 4'h1, 8'hFF);
        oie = 1'b1;
        cs_lo = 1'b1;
        wait_flag(2, t1);
        cyc(2);
        chk(ovf_i, 1'b1, "overflow request");
        flag_op(2, 1'b0, 1'b1, 1'b0);
        chk(ovf_f, 1'b1, "unread zero write");
        flag_op(2, 1'b1, 1'b0, 1'b0);
        flag_op(2, 1'b0, 1'b1, 1'b1);
        chk(ovf_f, 1'b1, "one write");
        clr(2);
        chk({ovf_f, ovf_i}, 2'h0, "qualified clear");
        wait_flag(2, t2);
        chk(16'((t2 - t1) / 10), 16'h0100, "up period");
        flag_op(2, 1'b1, 1'b0, 1'b0);
        cyc(260);
        flag_op(2, 1'b0, 1'b1, 1'b0);
        chk(ovf_f, 1'b1, "event mid-clear");
        clr(2);
        mode[1] = PTM_MODE_COMPARE;
        bus(3, 4'h2, 8'h00);
        bus(3, 4'h1, 8'h40);
        cyc(300);
        clr(1);
        wait_flag(1, t1);
        clr(1);
        wait_flag(1, t2);
        chk(16'((t2 - t1) / 10), 16'h0100, "compare period");
        bus(3, 4'h8, 8'h00);
        chk(cv_rd[1], 16'h0040, "compare load");
        cs_lo = 1'b0;
        bus(3, 4'h2, 8'h01);
        bus(3, 4'h1, 8'h23);
        bus(3, 4'h8, 8'h00);
        chk(cv_rd[1], 16'h0123, "stopped clock load");
    endtask : t_overflow

    task automatic t_capture();
        cie[0] = 1'b1;
        for (int c = 0; c < 4; c++)
        begin
            els_lo[0] = c[0];
            els_hi[0] = c[1];
            cyc(8);
            clr(0);
            lvl[0] = 1'b1;
            cyc(8);
            chk({ch_f[0], ch_i[0]}, {2{c[0]}}, "rising capture");
            clr(0);
            lvl[0] = 1'b0;
            cyc(8);
            chk(ch_f[0], c[1], "falling capture");
        end
        bus(2, 4'h2, 8'h12);
        bus(2, 4'h1, 8'h34);
        bus(2, 4'h8, 8'h00);
        chk(cv_rd[0] == 16'h1234, 1'b0, "capture write");
    endtask : t_capture

    task automatic t_debug();
        cs_hi = 1'b1;
        bus(1, 4'h2, 8'h0F);
        bus(1, 4'h1, 8'hFF);
        bus(0, 4'h1, 8'h5A);
        bus(0, 4'h8, 8'h00);
        chk(cnt_rd < 16'h0008, 1'b1, "counter clear");
        cyc(30);
        dbg = 1'b1;
        bus(0, 4'h4, 8'h00);
        v = cnt_rd;
        chk(v > 16'h0020, 1'b1, "debug read is live");
        cyc(10);
        bus(0, 4'h4, 8'h00);
        chk(cnt_rd, v, "debug read frozen");
        bus(0, 4'h8, 8'h00);
        flag_op(2, 1'b0, 1'b1, 1'b1);
        bus(0, 4'h2, 8'h00);
        bus(0, 4'h4, 8'h00);
        chk(cnt_rd, 16'h0000, "debug latch drop");
        bus(1, 4'h2, 8'h00);
        flag_op(2, 1'b0, 1'b1, 1'b1);
        bus(1, 4'h1, 8'h40);
        chk(modv == 16'h0040, 1'b0, "pending modulo byte");
        dbg = 1'b0;
    endtask : t_debug

    task automatic t_center();
        bus(1, 4'h2, 8'h00);
        bus(1, 4'h1, 8'h20);
        cas = 1'b1;
        mode[0] = PTM_MODE_CENTER_PWM;
        mode[1] = PTM_MODE_CENTER_PWM;
        bus(0, 4'h1, 8'h00);
        bus(2, 4'h3, 8'h00);
        cyc(100);
        clr(2);
        wait_flag(2, t1);
        clr(2);
        wait_flag(2, t2);
        chk(16'((t2 - t1) / 10), 16'h0040, "center period");
        v = {15'h0000, pwm[0]};
        e = edges;
        cyc(130);
        chk(edges - e, 16'h0000, "zero duty");
        bus(2, 4'h2, 8'h00);
        bus(2, 4'h1, 8'h20);
        cyc(150);
        e = edges;
        cyc(130);
        chk({edges == e, pwm[0]}, {1'b1, ~v[0]}, "full duty");
        bus(2, 4'h2, 8'h00);
        bus(2, 4'h1, 8'h08);
        cyc(150);
        clr(0);
        wait_flag(0, t1);
        clr(0);
        wait_flag(0, t2);
        clr(0);
        wait_flag(0, t3);
        chk(16'((t3 - t1) / 10), 16'h0040, "two matches");
    endtask : t_center

    initial
    begin
        {srst, dbg, cas, cs_hi, cs_lo, oie, tsc_wr, tsc_rd, tsc_wbit} = 9'h100;
        pdiv = 16'h0000;
        {cnt_acc, mod_acc, cv_acc} = '0;
        mode[0] = PTM_MODE_CAPTURE;
        mode[1] = PTM_MODE_CAPTURE;
        {csc_wr, csc_rd, csc_wbit, els_hi, els_lo, cie, lvl} = 14'h0000;
        err_total = 0;
        num_checks = 0;
        cyc(8);
        srst = 1'b0;
        t_overflow();
        t_capture();
        t_debug();
        t_center();
        tally_and_finish();
    end
endmodule : ptm_top_tb
`default_nettype wire
